// >>> hw/fbpc_cfg.svh
// Constants of the flash bus pin control block.
// Assumes it is included by bare name wherever widths or values are needed.
`ifndef FBPC_CFG_SVH
`define FBPC_CFG_SVH

`define FBPC_ADDR_W      26
`define FBPC_DATA_W      16
`define FBPC_STAT_W      8
`define FBPC_RCR_W       16
`define FBPC_CTRL_W      6
`define FBPC_TOP_BIT     25
`define FBPC_WAIT_POL    10
`define FBPC_STATUS_RST  8'h80
// Bit positions of the synchronised control pin group
`define FBPC_PIN_SEL     0
`define FBPC_PIN_OE      1
`define FBPC_PIN_WE      2
`define FBPC_PIN_RST     3
`define FBPC_PIN_ADV     4
`define FBPC_PIN_GUARD   5

`endif

// >>> hw/fbpc_pkg.sv
// Types shared by the flash bus pin control block.
// Assumes fbpc_cfg.svh is on the include path.
package fbpc_pkg;

  typedef enum logic [3:0]
  {
    ST_RESET      = 4'h1,
    ST_ASYNC_READ = 4'h2,
    ST_SYNC_READ  = 4'h4,
    ST_WRITE      = 4'h8
  } fbpc_state_t;

endpackage : fbpc_pkg

// >>> hw/fbpc_sync.sv
// Two flip-flop level synchroniser into the clock domain of clock.
// Assumes each bit is a level or a toggle; words must be held stable.
`timescale 1ns/1ps

module fbpc_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] dIn,
  output      logic [WIDTH-1:0] dOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage is read by the second stage only
  always_ff @(posedge clock)
  begin
    meta_q <= dIn;
    sync_q <= meta_q;
  end

  assign dOut = sync_q;

endmodule : fbpc_sync

// >>> hw/fbpc_bus_capture.sv
// Synchronous read address capture on the flash bus clock.
// Assumes the address-valid strobe and address are timed to busClk, and
// syncArm is a request toggle from the clock domain, one per ADV window.
`timescale 1ns/1ps
`include "fbpc_cfg.svh"

module fbpc_bus_capture
(
  input  wire logic                    busClk,
  input  wire logic                    rst,
  input  wire logic                    syncArm,
  input  wire logic                    advN,
  input  wire logic [`FBPC_ADDR_W-1:0] addrIn,
  output      logic [`FBPC_ADDR_W-1:0] capAddr,
  output      logic                    capToggle
);

  logic                    rstMeta_q;
  logic                    rstSync_q;
  logic                    armMeta_q;
  logic                    armSync_q;
  logic [`FBPC_ADDR_W-1:0] capAddr_q;
  logic                    capToggle_q;

  always_ff @(posedge busClk)
  begin
    rstMeta_q <= rst;
    rstSync_q <= rstMeta_q;
    armMeta_q <= syncArm;
    armSync_q <= armMeta_q;
  end

  // A request stays open until an edge with ADV low serves it, so a bus
  // clock that stops between windows loses no window; the word then stays
  // put until the next request, so the other side may sample it
  always_ff @(posedge busClk)
  begin
    if (rstSync_q)
    begin
      capToggle_q <= 1'b0;
      capAddr_q   <= '0;
    end
    else if ((armSync_q != capToggle_q) && !advN)
    begin
      capToggle_q <= armSync_q;
      capAddr_q   <= addrIn;
    end
  end

  assign capAddr   = capAddr_q;
  assign capToggle = capToggle_q;

endmodule : fbpc_bus_capture

// >>> hw/fbpc_top.sv
// Host bus pin control of one flash die: select, output drive, write
// strobe, reset, wait, lock guard and die routing.
// Assumes all pins are asynchronous to clock; core inputs are on clock.
//
// Notes on behaviour
// - Low die select selects the die and enables its control logic; sync read address capture runs whatever the select.
// - Deselected die goes to standby; data and wait float.
// - Sync read address taken on ADV rise or first bus clock ADV low after the arm request has passed two bus clock flops.
// - Data drivers enabled in reads only while output drive is low.
// - Output drive high floats data and wait.
// - Reset low resets the automation and refuses writes.
// - Leaving reset enters asynchronous array read.
// - Wait polarity follows read configuration bit 10.
// - In sync burst reads wait asserted while data is invalid.
// - Async page reads and writes keep wait deasserted.
// - Wait driven only while select and output drive are low.
// - Address and write data captured on write strobe rising edge.
// - Guard low enforces lock-down; unlock refused for such blocks.
// - Guard high overrides lock-down, allowing program and erase.
// - Top address bit high picks top die, low bottom die.
// - Reset sets status register to 0x80.
`timescale 1ns/1ps
`include "fbpc_cfg.svh"

module fbpc_top
  import fbpc_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    busClk,
  input  wire logic                    firstDieSelectN,
  input  wire logic                    firstDieOutDriveN,
  input  wire logic                    writeStrobeN,
  input  wire logic                    flashResetN,
  input  wire logic                    addrValidStrobeN,
  input  wire logic                    lockGuardN,
  input  wire logic [`FBPC_ADDR_W-1:0] addrIn,
  input  wire logic [`FBPC_DATA_W-1:0] dqIn,
  output      logic [`FBPC_DATA_W-1:0] dqOut,
  output      logic                    dqOe,
  output      logic                    waitOut,
  output      logic                    waitOe,
  input  wire logic [`FBPC_RCR_W-1:0]  readConfigReg,
  input  wire logic                    syncReadMode,
  input  wire logic                    burstDataValid,
  input  wire logic [`FBPC_DATA_W-1:0] arrayData,
  input  wire logic                    statusLoad,
  input  wire logic [`FBPC_STAT_W-1:0] statusIn,
  input  wire logic                    unlockCmd,
  input  wire logic                    blockInLockDown,
  output      logic [`FBPC_ADDR_W-1:0] readAddr,
  output      logic                    readAddrValid,
  output      logic [`FBPC_ADDR_W-1:0] writeAddr,
  output      logic [`FBPC_DATA_W-1:0] writeData,
  output      logic                    writeValid,
  output      logic                    topDieSel,
  output      logic [`FBPC_STAT_W-1:0] statusReg,
  output      logic                    unlockGrant,
  output      logic                    lockOverride,
  output      logic                    standby,
  output      logic [3:0]              modeState
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`FBPC_CTRL_W-1:0] pinS;
  logic [`FBPC_ADDR_W-1:0] addrS;
  logic [`FBPC_DATA_W-1:0] dqS;
  logic                    capTglS;
  logic [`FBPC_ADDR_W-1:0] capAddrL;
  logic                    capTglL;

  fbpc_sync #(.WIDTH(`FBPC_CTRL_W)) uSyncPins
  (
    .clock (clock),
    .dIn   ({lockGuardN, addrValidStrobeN, flashResetN,
             writeStrobeN, firstDieOutDriveN, firstDieSelectN}),
    .dOut  (pinS)
  );

  // Address and data are sampled on strobe edges, and the address also while ADV is low in async reads,
  // when the bus holds them stable, so bit skew through these stages is harmless
  fbpc_sync #(.WIDTH(`FBPC_ADDR_W)) uSyncAddr
  (
    .clock (clock),
    .dIn   (addrIn),
    .dOut  (addrS)
  );

  fbpc_sync #(.WIDTH(`FBPC_DATA_W)) uSyncData
  (
    .clock (clock),
    .dIn   (dqIn),
    .dOut  (dqS)
  );

  fbpc_sync #(.WIDTH(1)) uSyncCap
  (
    .clock (clock),
    .dIn   (capTglL),
    .dOut  (capTglS)
  );

  fbpc_state_t state_q;
  logic        armTgl_q;

  fbpc_bus_capture uCapture
  (
    .busClk    (busClk),
    .rst       (rst),
    .syncArm   (armTgl_q),
    .advN      (addrValidStrobeN),
    .addrIn    (addrIn),
    .capAddr   (capAddrL),
    .capToggle (capTglL)
  );

  logic selS;
  logic oeS;
  logic weS;
  logic rstS;
  logic advS;
  logic guardS;

  assign selS   = !pinS[`FBPC_PIN_SEL];
  assign oeS    = !pinS[`FBPC_PIN_OE];
  assign weS    = !pinS[`FBPC_PIN_WE];
  assign rstS   = !pinS[`FBPC_PIN_RST];
  assign advS   = !pinS[`FBPC_PIN_ADV];
  assign guardS = !pinS[`FBPC_PIN_GUARD];

  ////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic weS_q;
  logic advS_q;
  logic capTgl_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      weS_q    <= 1'b0;
      advS_q   <= 1'b0;
      capTgl_q <= 1'b0;
    end
    else
    begin
      weS_q    <= weS;
      advS_q   <= advS;
      capTgl_q <= capTglS;
    end
  end

  logic intReset;
  logic weRise;
  logic advRise;
  logic advFall;
  logic linkCap;
  logic writeOk;

  assign intReset = rst || rstS;
  assign weRise   = weS_q && !weS;
  assign advRise  = advS_q && !advS;
  assign advFall  = !advS_q && advS;
  assign linkCap  = capTgl_q ^ capTglS;
  // Write accepted only with select low, reset and drive high
  assign writeOk  = selS && !rstS && !oeS;

  // Pin combination that lets the die drive the bus
  function automatic logic busDrive(input logic sel, input logic oe,
                                    input logic rs);
    busDrive = sel && oe && !rs;
  endfunction : busDrive

  // One request per ADV window to the bus clock side; a request left open
  // by a window without bus clock is served in the next one. Reset by rst
  // only, as the far side resets on rst only.
  always_ff @(posedge clock)
  begin
    if (rst)
      armTgl_q <= 1'b0;
    else if (state_q == ST_SYNC_READ && advFall && armTgl_q == capTglS)
      armTgl_q <= ~armTgl_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode state

  always_ff @(posedge clock)
  begin
    if (intReset)
    begin
      state_q <= ST_RESET;
    end
    else
    begin
      unique case (state_q)
        ST_RESET:
        begin
          state_q <= ST_ASYNC_READ;
        end
        ST_ASYNC_READ, ST_SYNC_READ:
        begin
          if (selS && weS && !oeS)
            state_q <= ST_WRITE;
          else if (syncReadMode)
            state_q <= ST_SYNC_READ;
          else
            state_q <= ST_ASYNC_READ;
        end
        ST_WRITE:
        begin
          if (!weS || !selS)
            state_q <= syncReadMode ? ST_SYNC_READ : ST_ASYNC_READ;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address capture and die routing

  logic                    armed_q;
  logic [`FBPC_ADDR_W-1:0] readAddr_q;
  logic                    readAddrValid_q;
  logic                    topDieSel_q;

  always_ff @(posedge clock)
  begin
    if (intReset)
    begin
      armed_q         <= 1'b0;
      readAddr_q      <= '0;
      readAddrValid_q <= 1'b0;
      topDieSel_q     <= 1'b0;
    end
    else
    begin
      readAddrValid_q <= 1'b0;
      if (state_q == ST_SYNC_READ)
      begin
        if (advFall)
          armed_q <= 1'b1;
        // First of the two sources wins, the link capture if both come in one cycle; the later one is dropped
        if (armed_q && (advRise || linkCap))
        begin
          armed_q         <= 1'b0;
          readAddr_q      <= linkCap ? capAddrL : addrS;
          readAddrValid_q <= 1'b1;
          topDieSel_q     <= linkCap ? capAddrL[`FBPC_TOP_BIT]
                                     : addrS[`FBPC_TOP_BIT];
        end
      end
      else if (state_q == ST_ASYNC_READ && selS && advS)
      begin
        // Address flows through while ADV is low
        armed_q     <= 1'b0;
        readAddr_q  <= addrS;
        topDieSel_q <= addrS[`FBPC_TOP_BIT];
      end
      else if (writeOk && weRise)
      begin
        topDieSel_q <= addrS[`FBPC_TOP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write capture

  logic [`FBPC_ADDR_W-1:0] writeAddr_q;
  logic [`FBPC_DATA_W-1:0] writeData_q;
  logic                    writeValid_q;

  always_ff @(posedge clock)
  begin
    if (intReset)
    begin
      writeAddr_q  <= '0;
      writeData_q  <= '0;
      writeValid_q <= 1'b0;
    end
    else
    begin
      writeValid_q <= writeOk && weRise;
      if (writeOk && weRise)
      begin
        writeAddr_q <= addrS;
        writeData_q <= dqS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data and wait drivers

  logic [`FBPC_DATA_W-1:0] dqOut_q;
  logic                    dqOe_q;
  logic                    waitOut_q;
  logic                    waitOe_q;
  logic                    waitAct;

  assign waitAct = (state_q == ST_SYNC_READ) && !burstDataValid;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dqOut_q   <= '0;
      dqOe_q    <= 1'b0;
      waitOut_q <= 1'b0;
      waitOe_q  <= 1'b0;
    end
    else
    begin
      dqOut_q   <= arrayData;
      dqOe_q    <= busDrive(selS, oeS, rstS) && !weS
                   && state_q != ST_WRITE;
      waitOe_q  <= busDrive(selS, oeS, rstS);
      // Deasserted level is the inverse of the configured polarity
      waitOut_q <= waitAct ? readConfigReg[`FBPC_WAIT_POL]
                           : !readConfigReg[`FBPC_WAIT_POL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, lock guard, standby

  logic [`FBPC_STAT_W-1:0] statusReg_q;
  logic                    unlockGrant_q;
  logic                    lockOverride_q;
  logic                    standby_q;

  always_ff @(posedge clock)
  begin
    if (intReset)
      statusReg_q <= `FBPC_STATUS_RST;
    else if (statusLoad)
      statusReg_q <= statusIn;
  end

  always_ff @(posedge clock)
  begin
    if (intReset)
    begin
      unlockGrant_q  <= 1'b0;
      lockOverride_q <= 1'b0;
    end
    else
    begin
      unlockGrant_q  <= unlockCmd && (!blockInLockDown || !guardS);
      lockOverride_q <= !guardS;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      standby_q <= 1'b1;
    else
      standby_q <= !selS;
  end

  assign dqOut         = dqOut_q;
  assign dqOe          = dqOe_q;
  assign waitOut       = waitOut_q;
  assign waitOe        = waitOe_q;
  assign readAddr      = readAddr_q;
  assign readAddrValid = readAddrValid_q;
  assign writeAddr     = writeAddr_q;
  assign writeData     = writeData_q;
  assign writeValid    = writeValid_q;
  assign topDieSel     = topDieSel_q;
  assign statusReg     = statusReg_q;
  assign unlockGrant   = unlockGrant_q;
  assign lockOverride  = lockOverride_q;
  assign standby       = standby_q;
  assign modeState     = state_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_standby_float;
    @(posedge clock) disable iff (rst)
    !selS |=> !dqOe_q && !waitOe_q && standby_q;
  endproperty
  a_standby_float: assert property (p_standby_float)
    else $error("output driven while deselected");

  property p_oe_float;
    @(posedge clock) disable iff (rst)
    !oeS |=> !dqOe_q && !waitOe_q;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("output driven with output drive high");

  property p_dq_cause;
    @(posedge clock) disable iff (rst)
    dqOe_q |-> $past(selS && oeS && !rstS && !weS);
  endproperty
  a_dq_cause: assert property (p_dq_cause)
    else $error("data driven without read conditions");

  property p_wait_drive;
    @(posedge clock) disable iff (rst)
    selS && oeS && !rstS |=> waitOe_q;
  endproperty
  a_wait_drive: assert property (p_wait_drive)
    else $error("wait not driven while selected and enabled");

  property p_wait_sync;
    @(posedge clock) disable iff (rst)
    state_q == ST_SYNC_READ && !burstDataValid
      |=> waitOut_q == $past(readConfigReg[`FBPC_WAIT_POL]);
  endproperty
  a_wait_sync: assert property (p_wait_sync)
    else $error("wait not asserted for invalid burst data");

  property p_wait_idle;
    @(posedge clock) disable iff (rst)
    state_q == ST_ASYNC_READ || state_q == ST_WRITE
      |=> waitOut_q != $past(readConfigReg[`FBPC_WAIT_POL]);
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("wait asserted outside sync reads");

  property p_reset_refuse;
    @(posedge clock) disable iff (rst)
    rstS |=> state_q == ST_RESET && !writeValid_q;
  endproperty
  a_reset_refuse: assert property (p_reset_refuse)
    else $error("reset did not stop the automation");

  property p_reset_exit;
    @(posedge clock) disable iff (rst)
    state_q == ST_RESET && !rstS |=> state_q == ST_ASYNC_READ;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("reset exit not to async array read");

  property p_status_init;
    @(posedge clock) disable iff (rst)
    state_q == ST_RESET |-> statusReg_q == `FBPC_STATUS_RST;
  endproperty
  a_status_init: assert property (p_status_init)
    else $error("status not initialised");

  property p_write_capture;
    @(posedge clock) disable iff (rst)
    writeOk && weRise |=> writeValid_q && writeAddr_q == $past(addrS)
      && writeData_q == $past(dqS)
      && topDieSel_q == writeAddr_q[`FBPC_TOP_BIT];
  endproperty
  a_write_capture: assert property (p_write_capture)
    else $error("write strobe rise not captured");

  property p_lock_down;
    @(posedge clock) disable iff (rst)
    !rstS && guardS && blockInLockDown |=> !unlockGrant_q;
  endproperty
  a_lock_down: assert property (p_lock_down)
    else $error("lock-down block released");

endmodule : fbpc_top

// >>> sim/fbpc_host_model.sv
// Host controller model that drives the flash bus pins of one die.
// Assumes the bench calls its tasks; pins move on clock falling edges, except the bus clock, which runs on its own 15 ns period.
`timescale 1ns/1ps
`include "fbpc_cfg.svh"

module fbpc_host_model
(
  input  wire logic                    clock,
  output      logic                    busClk,
  output      logic                    firstDieSelectN,
  output      logic                    firstDieOutDriveN,
  output      logic                    writeStrobeN,
  output      logic                    flashResetN,
  output      logic                    addrValidStrobeN,
  output      logic                    lockGuardN,
  output      logic [`FBPC_ADDR_W-1:0] addrIn,
  output      logic [`FBPC_DATA_W-1:0] dqIn
);
  initial
  begin
    busClk = 1'b0;
    {firstDieSelectN, firstDieOutDriveN, writeStrobeN} = 3'h7;
    {flashResetN, addrValidStrobeN, lockGuardN} = 3'h7;
    addrIn = 26'h000_0000;
    dqIn = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic setCtl(input logic [3:0] c);
    @(negedge clock);
    {firstDieSelectN, firstDieOutDriveN, flashResetN, lockGuardN} <= c;
  endtask : setCtl

  // Link clock runs only inside a frame, idle low between frames
  task automatic clkFrame(input int n);
    #3;
    repeat (n)
    begin
      busClk = 1'b1;
      #7.5;
      busClk = 1'b0;
      #7.5;
    end
  endtask : clkFrame

  task automatic doWrite(input logic [`FBPC_ADDR_W-1:0] a,
                         input logic [`FBPC_DATA_W-1:0] d);
    @(negedge clock);
    addrIn <= a;
    dqIn <= d;
    writeStrobeN <= 1'b0;
    repeat (3) @(negedge clock);
    writeStrobeN <= 1'b1;
    repeat (4) @(negedge clock);
    // Released data lines must not keep the last word
    dqIn <= ~d;
  endtask : doWrite

  task automatic doSync(input logic [`FBPC_ADDR_W-1:0] a, input logic useClk);
    @(negedge clock);
    addrIn <= a;
    addrValidStrobeN <= 1'b0;
    repeat (4) @(negedge clock);
    if (useClk)
      clkFrame(3);
    @(negedge clock);
    addrValidStrobeN <= 1'b1;
    repeat (6) @(negedge clock);
  endtask : doSync
endmodule : fbpc_host_model

// >>> sim/tb_top.sv
// Self-checking bench of the flash bus pin control block.
// Assumes the host model drives the pins; core inputs are driven here.
`timescale 1ns/1ps
`include "fbpc_cfg.svh"

module tb_top
  import fbpc_pkg::*;
;
  logic clock, rst, busClk, firstDieSelectN, firstDieOutDriveN;
  logic writeStrobeN, flashResetN, addrValidStrobeN, lockGuardN;
  logic syncReadMode, burstDataValid, statusLoad, unlockCmd;
  logic blockInLockDown, dqOe, waitOut, waitOe, readAddrValid;
  logic writeValid, topDieSel, unlockGrant, lockOverride, standby;
  logic [`FBPC_ADDR_W-1:0] addrIn, readAddr, writeAddr;
  logic [`FBPC_DATA_W-1:0] dqIn, dqOut, arrayData, writeData;
  logic [`FBPC_STAT_W-1:0] statusIn, statusReg;
  logic [`FBPC_RCR_W-1:0]  readConfigReg;
  logic [3:0]              modeState;
  logic [41:0]             wrQ[$], rdQ[$], grQ[$];
  int                      errors, tests_run, cycles;

  fbpc_top u_fbpc_top (.clock, .rst, .busClk, .firstDieSelectN,
    .firstDieOutDriveN, .writeStrobeN, .flashResetN, .addrValidStrobeN,
    .lockGuardN, .addrIn, .dqIn, .dqOut, .dqOe, .waitOut, .waitOe,
    .readConfigReg, .syncReadMode, .burstDataValid, .arrayData,
    .statusLoad, .statusIn, .unlockCmd, .blockInLockDown, .readAddr,
    .readAddrValid, .writeAddr, .writeData, .writeValid, .topDieSel,
    .statusReg, .unlockGrant, .lockOverride, .standby, .modeState);

  fbpc_host_model u_fbpc_host_model (.clock, .busClk, .firstDieSelectN,
    .firstDieOutDriveN, .writeStrobeN, .flashResetN, .addrValidStrobeN,
    .lockGuardN, .addrIn, .dqIn);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic cmpLevel(input string what, input logic [15:0] got,
                          input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmpLevel

  // An event with no note pending compares against unknown and fails
  task automatic cmpEvent(input string what, input logic [41:0] got,
                          ref logic [41:0] q[$]);
    logic [41:0] exp;
    tests_run++;
    exp = (q.size() > 0) ? q.pop_front() : 'x;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmpEvent

  always @(negedge clock)
  begin
    if (!rst && writeValid !== 1'b0)
      cmpEvent("write", {writeAddr, writeData}, wrQ);
    if (!rst && readAddrValid !== 1'b0)
      cmpEvent("addr", 42'(readAddr), rdQ);
    if (!rst && unlockGrant !== 1'b0)
      cmpEvent("grant", 42'(unlockGrant), grQ);
  end

  // The whole sequence needs about 250 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [`FBPC_ADDR_W-1:0] a;
    logic [`FBPC_DATA_W-1:0] d;
    logic                    m, p, v;
    {rst, syncReadMode, burstDataValid, statusLoad, unlockCmd} = 5'h10;
    {blockInLockDown, statusIn, readConfigReg} = 25'h000_0000;
    arrayData = 16'h0000;
    void'($urandom(27022));
    // The link side only resets on link clock edges
    fork
      u_fbpc_host_model.clkFrame(3);
    join_none
    repeat (3) @(negedge clock);
    cmpLevel("standby", 16'(standby), 16'h0001);
    cmpLevel("status", 16'(statusReg), 16'h0080);
    cmpLevel("mode", 16'(modeState), 16'(ST_RESET));
    cmpLevel("oe", 16'({dqOe, waitOe}), 16'h0000);
    @(negedge clock);
    rst = 1'b0;
    a = 26'($urandom());
    u_fbpc_host_model.doWrite(a, 16'($urandom()));
    cmpLevel("standby", 16'(standby), 16'h0001);
    u_fbpc_host_model.setCtl(4'h7);
    repeat (4)
    begin
      a = 26'($urandom());
      d = 16'($urandom());
      burstDataValid = 1'($urandom());
      blockInLockDown = 1'($urandom());
      wrQ.push_back({a, d});
      u_fbpc_host_model.doWrite(a, d);
      cmpLevel("top", 16'(topDieSel), 16'(a[`FBPC_TOP_BIT]));
    end
    u_fbpc_host_model.setCtl(4'h3);
    u_fbpc_host_model.doWrite(a, d);
    arrayData = 16'($urandom());
    repeat (6) @(negedge clock);
    cmpLevel("standby", 16'(standby), 16'h0000);
    cmpLevel("oe", 16'({dqOe, waitOe}), 16'h0003);
    cmpLevel("dq", dqOut, arrayData);
    u_fbpc_host_model.setCtl(4'h7);
    repeat (6) @(negedge clock);
    cmpLevel("oe", 16'({dqOe, waitOe}), 16'h0000);
    u_fbpc_host_model.setCtl(4'hB);
    repeat (6) @(negedge clock);
    cmpLevel("oe", 16'({dqOe, waitOe, standby}), 16'h0001);
    u_fbpc_host_model.setCtl(4'h3);
    for (int i = 0; i < 8; i++)
    begin
      {m, p, v} = 3'(i);
      readConfigReg = 16'($urandom());
      readConfigReg[`FBPC_WAIT_POL] = p;
      syncReadMode = m;
      burstDataValid = v;
      repeat (6) @(negedge clock);
      cmpLevel("mode", 16'(modeState),
               m ? 16'(ST_SYNC_READ) : 16'(ST_ASYNC_READ));
      cmpLevel("wait", 16'(waitOut), 16'((m && !v) ? p : !p));
    end
    for (int i = 0; i < 4; i++)
    begin
      a = 26'($urandom());
      rdQ.push_back(42'(a));
      u_fbpc_host_model.doSync(a, i[0]);
      cmpLevel("top", 16'(topDieSel), 16'(a[`FBPC_TOP_BIT]));
    end
    for (int i = 0; i < 4; i++)
    begin
      u_fbpc_host_model.setCtl({3'h1, i[1]});
      blockInLockDown = i[0];
      m = 1'($urandom());
      v = 1'($urandom());
      syncReadMode = m;
      burstDataValid = v;
      repeat (6) @(negedge clock);
      cmpLevel("override", 16'(lockOverride), 16'(i[1]));
      cmpLevel("wait", 16'(waitOut), 16'((m && !v) ? p : !p));
      if (!i[0] || i[1])
        grQ.push_back(42'h000_0000_0001);
      unlockCmd = 1'b1;
      @(negedge clock);
      unlockCmd = 1'b0;
      repeat (3) @(negedge clock);
    end
    statusIn = 8'($urandom()) & 8'h7F;
    statusLoad = 1'b1;
    @(negedge clock);
    statusLoad = 1'b0;
    @(negedge clock);
    cmpLevel("status", 16'(statusReg), 16'(statusIn));
    syncReadMode = 1'b0;
    u_fbpc_host_model.setCtl(4'h1);
    repeat (6) @(negedge clock);
    cmpLevel("mode", 16'(modeState), 16'(ST_RESET));
    cmpLevel("oe", 16'({dqOe, waitOe}), 16'h0000);
    cmpLevel("status", 16'(statusReg), 16'h0080);
    u_fbpc_host_model.setCtl(4'h5);
    u_fbpc_host_model.doWrite(a, d);
    u_fbpc_host_model.setCtl(4'h7);
    repeat (6) @(negedge clock);
    cmpLevel("mode", 16'(modeState), 16'(ST_ASYNC_READ));
    cmpLevel("status", 16'(statusReg), 16'h0080);
    cmpLevel("left", 16'(wrQ.size() + rdQ.size() + grQ.size()), 16'h0000);
    results();
  end
endmodule : tb_top
